// ---- src/fmpc_top.sv ----
// Lock protection, quick start, current limit and shutdown sequencing for a fan pre-driver
`timescale 1ns/1ps
//
// Overview of operation
// - Enter lock when no Hall zero crossing for the lock-detect term.
// - On lock, high sides off for one lock term, then high and low sides off; the PWM gate is not affected by lock.
// - Resume drive automatically after the restart-wait term from lock entry.
// - Speed pulse output follows Hall input even during lock.
// - Two Hall crossings during restart clear lock and drop the lock flag.
// - Timing select band sets terms and standby; lowest band disables lock.
// - 39k pull-up band: 0.6 s detect, 6.0 s wait, no standby.
// - 120k pull-up band: 6.0 s wait, standby allowed.
// - 75k pull-down: 0.3/6.0 s; 18k pull-down: 0.3/4.5 s; standby allowed.
// - PWM variant: duty low for stop term in wait clears lock; restart on pulses.
// - Quick start disabled when minimum duty is configured.
// - With startup duty threshold, quick start needs duty at or below it for stop term.
// - Analog variant: command low for short stop term in wait clears lock.
// - With startup voltage threshold, quick start needs command at or below it for short term.
// - Filtered overcurrent turns high side off until next PWM on instant.
// - Overcurrent acts only after persisting through a 1 us filter.
// - Overtemperature: PWM off until three Hall edges or 5 Hz, then all off.
// - Normal operation resumes as soon as overtemperature clears.
// - Motor supply undervoltage shuts all drive until recovery.
// - Regulator undervoltage also shuts drive until recovery.
// - Hall frequency at or below 5 Hz selects square-wave drive.
module fmpc_top #(
  parameter int unsigned TICK_CYCLES = fmpc_pkg::FMPC_TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic hall_i,
  input wire logic [2:0] lock_timing_select_i,
  input wire logic analog_variant_i,
  input wire logic pwm_duty_in_i,
  input wire logic analog_speed_low_i,
  input wire logic min_duty_select_i,
  input wire logic startup_thresh_set_i,
  input wire logic below_startup_thresh_i,
  input wire logic pwm_on_i,
  input wire logic current_sense_in_i,
  input wire logic overtemp_shutdown_i,
  input wire logic motor_supply_uv_i,
  input wire logic regulator_out_uv_i,
  output logic high_side_en_o,
  output logic low_side_en_o,
  output logic pwm_gate_o,
  output logic square_wave_mode_o,
  output logic standby_allowed_o,
  output logic speed_pulse_out_o,
  output logic lock_flag_out_o
);
  import fmpc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisation
  logic [9:0] pins_s;
  logic hall_s;
  logic duty_s;
  logic vsp_low_s;
  logic below_s;
  logic pwm_on_s;
  logic oc_s;
  logic tsd_s;
  logic vm_uv_s;
  logic regulator_out_uv_s;
  logic analog_s;

  fmpc_sync #(.WIDTH(10)) u_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .async_i({hall_i, pwm_duty_in_i, analog_speed_low_i, below_startup_thresh_i, pwm_on_i,
              current_sense_in_i, overtemp_shutdown_i, motor_supply_uv_i, regulator_out_uv_i,
              analog_variant_i}),
    .sync_o(pins_s)
  );
  assign {hall_s, duty_s, vsp_low_s, below_s, pwm_on_s, oc_s, tsd_s, vm_uv_s, regulator_out_uv_s, analog_s} = pins_s;

  //////////////////////////////////////////////////////////////////////////////
  // Prescaler tick
  localparam int PRE_W = $clog2(TICK_CYCLES + 1);
  logic [PRE_W-1:0] pre_q;
  logic tick_q;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pre_q <= '0;
      tick_q <= 1'b0;
    end else if (pre_q == PRE_W'(TICK_CYCLES - 1)) begin
      pre_q <= '0;
      tick_q <= 1'b1;
    end else begin
      pre_q <= pre_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Timing band sampled once after reset
  fmpc_band_type band_q;
  logic band_taken_q;
  logic [FMPC_TERM_W-1:0] on_term;
  logic [FMPC_TERM_W-1:0] off_term;
  logic lock_enabled;
  logic standby_ok;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      band_q <= FMPC_BAND_OFF;
      band_taken_q <= 1'b0;
    end else if (!band_taken_q) begin
      band_q <= fmpc_band_type'(lock_timing_select_i);
      band_taken_q <= 1'b1;
    end
  end

  always_comb begin
    on_term = FMPC_T_0P3_MS;
    off_term = FMPC_T_3P0_MS;
    standby_ok = 1'b1;
    lock_enabled = 1'b1;
    unique case (band_q)
      FMPC_BAND_OFF: begin
        lock_enabled = 1'b0;
        standby_ok = 1'b0;
      end
      FMPC_BAND_PD18K: off_term = FMPC_T_4P5_MS;
      FMPC_BAND_PD75K: off_term = FMPC_T_6P0_MS;
      FMPC_BAND_OPEN: off_term = FMPC_T_3P0_MS;
      FMPC_BAND_PU120K: begin
        on_term = FMPC_T_0P6_MS;
        off_term = FMPC_T_6P0_MS;
      end
      FMPC_BAND_PU39K: begin
        on_term = FMPC_T_0P6_MS;
        off_term = FMPC_T_6P0_MS;
        standby_ok = 1'b0;
      end
      default: standby_ok = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Hall edge detection and low-frequency detection
  logic hall_d1_q;
  logic hall_edge;
  logic lowfreq;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      hall_d1_q <= 1'b0;
    end else begin
      hall_d1_q <= hall_s;
    end
  end
  assign hall_edge = hall_s ^ hall_d1_q;

  fmpc_term_timer #(.WIDTH(FMPC_TERM_W)) u_lowfreq (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .tick_i(tick_q),
    .run_i(!hall_edge),
    .term_i(FMPC_LOWFREQ_MS),
    .done_o(lowfreq)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Lock protection state machine
  fmpc_lock_state_type lock_q;
  logic [FMPC_TERM_W-1:0] lock_cnt_q;
  logic [FMPC_TERM_W-1:0] off_cnt_q;
  logic [1:0] restart_edges_q;
  logic stall_done;
  logic quick_clear;
  logic quick_clear_q;

  fmpc_term_timer #(.WIDTH(FMPC_TERM_W)) u_stall (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .tick_i(tick_q),
    .run_i(!hall_edge && lock_q == FMPC_RUN && lock_enabled),
    .term_i(on_term),
    .done_o(stall_done)
  );

  // Quick start qualification: command held low for the variant's stop term
  logic qs_low;
  logic qs_done;
  assign qs_low = analog_s ? (startup_thresh_set_i ? below_s : vsp_low_s)
                           : (startup_thresh_set_i ? below_s : !duty_s);

  fmpc_term_timer #(.WIDTH(FMPC_TERM_W)) u_quick (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .tick_i(tick_q),
    .run_i(qs_low && lock_q == FMPC_LOCK_OFF && !min_duty_select_i),
    .term_i(analog_s ? FMPC_VSP_STOP_MS : FMPC_DUTY_STOP_MS),
    .done_o(qs_done)
  );

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      lock_q <= FMPC_RUN;
      lock_cnt_q <= '0;
      off_cnt_q <= '0;
      restart_edges_q <= 2'h0;
      quick_clear_q <= 1'b0;
    end else begin
      if (lock_q != FMPC_RUN && tick_q && off_cnt_q < off_term) begin
        off_cnt_q <= off_cnt_q + 1'b1;
      end
      unique case (lock_q)
        FMPC_RUN: begin
          off_cnt_q <= '0;
          lock_cnt_q <= '0;
          quick_clear_q <= 1'b0;
          if (stall_done) begin
            lock_q <= FMPC_LOCK_HS;
          end
        end
        FMPC_LOCK_HS: begin
          if (tick_q) begin
            lock_cnt_q <= lock_cnt_q + 1'b1;
          end
          if (lock_cnt_q >= on_term) begin
            lock_q <= FMPC_LOCK_OFF;
          end
        end
        FMPC_LOCK_OFF: begin
          if (qs_done) begin
            quick_clear_q <= 1'b1;
          end
          if (quick_clear_q && !qs_low) begin
            lock_q <= FMPC_RUN;
          // A lock cleared by quick start waits for the command, not for a retry
          end else if (!quick_clear_q && off_cnt_q >= off_term) begin
            lock_q <= FMPC_RESTART;
            restart_edges_q <= 2'h0;
            lock_cnt_q <= '0;
          end
        end
        FMPC_RESTART: begin
          if (hall_edge) begin
            restart_edges_q <= restart_edges_q + 1'b1;
          end
          if (tick_q) begin
            lock_cnt_q <= lock_cnt_q + 1'b1;
          end
          if (hall_edge && restart_edges_q == FMPC_RESTART_EDGES - 2'h1) begin
            lock_q <= FMPC_RUN;
          end else if (lock_cnt_q >= on_term) begin
            lock_q <= FMPC_LOCK_HS;
            lock_cnt_q <= '0;
            off_cnt_q <= '0;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Overcurrent filter and latch
  localparam int OC_W = $clog2(FMPC_OC_FILTER_CYCLES + 1);
  logic [OC_W-1:0] oc_cnt_q;
  logic oc_latch_q;
  logic pwm_on_d1_q;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      oc_cnt_q <= '0;
      oc_latch_q <= 1'b0;
      pwm_on_d1_q <= 1'b0;
    end else begin
      pwm_on_d1_q <= pwm_on_s;
      if (!oc_s) begin
        oc_cnt_q <= '0;
      end else if (oc_cnt_q < OC_W'(FMPC_OC_FILTER_CYCLES)) begin
        oc_cnt_q <= oc_cnt_q + 1'b1;
      end
      if (oc_cnt_q == OC_W'(FMPC_OC_FILTER_CYCLES)) begin
        oc_latch_q <= 1'b1;
      end else if (pwm_on_s && !pwm_on_d1_q) begin
        oc_latch_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Thermal shutdown sequence
  fmpc_tsd_state_type tsd_q;
  logic [1:0] tsd_edges_q;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      tsd_q <= FMPC_TSD_IDLE;
      tsd_edges_q <= 2'h0;
    end else if (!tsd_s) begin
      tsd_q <= FMPC_TSD_IDLE;
      tsd_edges_q <= 2'h0;
    end else begin
      unique case (tsd_q)
        FMPC_TSD_IDLE: tsd_q <= FMPC_TSD_PWM_OFF;
        FMPC_TSD_PWM_OFF: begin
          if (hall_edge) begin
            tsd_edges_q <= tsd_edges_q + 1'b1;
          end
          if ((hall_edge && tsd_edges_q == FMPC_TSD_HALL_EDGES - 2'h1) || lowfreq) begin
            tsd_q <= FMPC_TSD_ALL_OFF;
          end
        end
        FMPC_TSD_ALL_OFF: tsd_q <= FMPC_TSD_ALL_OFF;
        default: tsd_q <= FMPC_TSD_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output registers
  logic uv;
  assign uv = vm_uv_s || regulator_out_uv_s;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      high_side_en_o <= 1'b0;
      low_side_en_o <= 1'b0;
      pwm_gate_o <= 1'b0;
      square_wave_mode_o <= 1'b0;
      standby_allowed_o <= 1'b0;
      speed_pulse_out_o <= 1'b0;
      lock_flag_out_o <= 1'b0;
    end else begin
      low_side_en_o <= !uv && tsd_q != FMPC_TSD_ALL_OFF && lock_q != FMPC_LOCK_OFF;
      high_side_en_o <= !uv && tsd_q != FMPC_TSD_ALL_OFF && !oc_latch_q
                        && (lock_q == FMPC_RUN || lock_q == FMPC_RESTART);
      pwm_gate_o <= !uv && tsd_q == FMPC_TSD_IDLE && !oc_latch_q;
      square_wave_mode_o <= lowfreq;
      standby_allowed_o <= standby_ok && !min_duty_select_i;
      speed_pulse_out_o <= hall_s;
      // Quick start clears the lock before the command returns and drive resumes
      lock_flag_out_o <= lock_q != FMPC_RUN && !quick_clear_q;
    end
  end
endmodule : fmpc_top

// ---- src/fmpc_pkg.sv ----
// Package of constants and types for the fan motor protection control block
package fmpc_pkg;
  // Timing select bands, lowest voltage band first
  typedef enum logic [2:0] {
    FMPC_BAND_OFF = 3'h0,
    FMPC_BAND_PD18K = 3'h1,
    FMPC_BAND_PD75K = 3'h2,
    FMPC_BAND_OPEN = 3'h3,
    FMPC_BAND_PU120K = 3'h4,
    FMPC_BAND_PU39K = 3'h5,
    FMPC_BAND_SHORT = 3'h6
  } fmpc_band_type;

  typedef enum logic [1:0] {
    FMPC_RUN = 2'h0,
    FMPC_LOCK_HS = 2'h1,
    FMPC_LOCK_OFF = 2'h2,
    FMPC_RESTART = 2'h3
  } fmpc_lock_state_type;

  typedef enum logic [1:0] {
    FMPC_TSD_IDLE = 2'h0,
    FMPC_TSD_PWM_OFF = 2'h1,
    FMPC_TSD_ALL_OFF = 2'h2
  } fmpc_tsd_state_type;

  localparam int unsigned FMPC_CLK_HZ = 125000000;
  localparam int unsigned FMPC_CLK_PERIOD_NS = 8;
  // Prescaler gives a 1 ms tick; protection terms are counted in ticks
  localparam int unsigned FMPC_TICK_US = 1000;
  localparam int unsigned FMPC_TICK_CYCLES = FMPC_TICK_US * (FMPC_CLK_HZ / 1000000);
  localparam int unsigned FMPC_TERM_W = 13;
  // Terms in milliseconds
  localparam logic [12:0] FMPC_T_0P3_MS = 13'h012c;
  localparam logic [12:0] FMPC_T_0P6_MS = 13'h0258;
  localparam logic [12:0] FMPC_T_3P0_MS = 13'h0bb8;
  localparam logic [12:0] FMPC_T_4P5_MS = 13'h1194;
  localparam logic [12:0] FMPC_T_6P0_MS = 13'h1770;
  localparam logic [12:0] FMPC_DUTY_STOP_MS = 13'h0064;
  localparam logic [12:0] FMPC_VSP_STOP_MS = 13'h000a;
  // 5 Hz means a Hall period of 200 ms, so one half period of 100 ms
  localparam logic [12:0] FMPC_LOWFREQ_MS = 13'h0064;
  // Current filter: 1 us at 8 ns rounds up to 125 cycles
  localparam int unsigned FMPC_OC_FILTER_NS = 1000;
  localparam int unsigned FMPC_OC_FILTER_CYCLES =
    (FMPC_OC_FILTER_NS + FMPC_CLK_PERIOD_NS - 1) / FMPC_CLK_PERIOD_NS;
  localparam logic [1:0] FMPC_TSD_HALL_EDGES = 2'h3;
  localparam logic [1:0] FMPC_RESTART_EDGES = 2'h2;
endpackage : fmpc_pkg

// ---- src/fmpc_sync.sv ----
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
module fmpc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule : fmpc_sync

// ---- src/fmpc_term_timer.sv ----
// Tick-driven term counter that flags when a level has held for a term
`timescale 1ns/1ps
module fmpc_term_timer #(
  parameter int WIDTH = 13
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic tick_i,
  input wire logic run_i,
  input wire logic [WIDTH-1:0] term_i,
  output logic done_o
);
  logic [WIDTH-1:0] count_q;

  // Counter restarts whenever run drops; done holds while run stays high
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || !run_i) begin
      count_q <= '0;
    end else if (tick_i && count_q < term_i) begin
      count_q <= count_q + 1'b1;
    end
  end

  assign done_o = run_i && (count_q >= term_i);
endmodule : fmpc_term_timer

// ---- dv/fmpc_monitor.sv ----
// Concurrent checks on the fan motor protection control ports
`timescale 1ns/1ps
module fmpc_monitor #(
  parameter int unsigned TICK_CYCLES = 4
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic hall_i,
  input wire logic current_sense_in_i,
  input wire logic overtemp_shutdown_i,
  input wire logic motor_supply_uv_i,
  input wire logic regulator_out_uv_i,
  input wire logic high_side_en_o,
  input wire logic low_side_en_o,
  input wire logic pwm_gate_o,
  input wire logic square_wave_mode_o,
  input wire logic speed_pulse_out_o,
  input wire logic lock_flag_out_o
);
  localparam int unsigned LOCK_MIN = 299 * TICK_CYCLES;
  localparam int unsigned SQ_MIN = 99 * TICK_CYCLES;
  localparam int unsigned OC_MIN = 124;
  logic hall_q;
  int unsigned idle_q;
  int unsigned oc_q;
  logic [2:0] age_q;
  ////////////////////////////////////////
  // Quiet time on the Hall pin, overcurrent run length, time since reset
  always_ff @(posedge clk_i) begin
    hall_q <= hall_i;
    if (!reset_n_i || hall_i != hall_q) idle_q <= 32'h0;
    else if (idle_q < 32'h000fffff) idle_q <= idle_q + 32'h1;
  end
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || !current_sense_in_i) oc_q <= 32'h0;
    else if (oc_q < 32'h3e8) oc_q <= oc_q + 32'h1;
  end
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) age_q <= 3'h0;
    else if (age_q != 3'h7) age_q <= age_q + 3'h1;
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_lock_entry;
    $rose(lock_flag_out_o);
  endsequence
  sequence s_low_holds;
    (!high_side_en_o && low_side_en_o) [*8];
  endsequence
  property p_rst_quiet;
    $rose(reset_n_i) |-> !lock_flag_out_o && !high_side_en_o && !low_side_en_o && !pwm_gate_o;
  endproperty
  property p_lock_quiet;
    s_lock_entry |-> idle_q >= LOCK_MIN;
  endproperty
  property p_lock_order;
    s_lock_entry |-> s_low_holds;
  endproperty
  property p_square;
    $rose(square_wave_mode_o) |-> idle_q >= SQ_MIN;
  endproperty
  property p_speed;
    age_q == 3'h7 |-> speed_pulse_out_o == $past(hall_i, 3);
  endproperty
  property p_motor_uv;
    motor_supply_uv_i [*4] |-> !high_side_en_o && !low_side_en_o;
  endproperty
  property p_reg_uv;
    regulator_out_uv_i [*4] |-> !high_side_en_o && !low_side_en_o;
  endproperty
  property p_tsd_pwm;
    overtemp_shutdown_i [*5] |-> !pwm_gate_o;
  endproperty
  property p_oc_filter;
    $fell(high_side_en_o) && !lock_flag_out_o && !overtemp_shutdown_i && !motor_supply_uv_i &&
      !regulator_out_uv_i |-> oc_q >= OC_MIN;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not low after reset");
  a_lock_quiet: assert property (p_lock_quiet) else $error("lock entered too early");
  a_lock_order: assert property (p_lock_order) else $error("lock drive order wrong");
  a_square: assert property (p_square) else $error("square wave mode too early");
  a_speed: assert property (p_speed) else $error("speed pulse does not follow hall");
  a_motor_uv: assert property (p_motor_uv) else $error("drive on in motor undervoltage");
  a_reg_uv: assert property (p_reg_uv) else $error("drive on in regulator undervoltage");
  a_tsd_pwm: assert property (p_tsd_pwm) else $error("pwm on in overtemperature");
  a_oc_filter: assert property (p_oc_filter) else $error("current limit acted before filter");
endmodule : fmpc_monitor

bind fmpc_top fmpc_monitor #(.TICK_CYCLES(TICK_CYCLES)) mon_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .hall_i(hall_i), .current_sense_in_i(current_sense_in_i), .overtemp_shutdown_i(overtemp_shutdown_i),
  .motor_supply_uv_i(motor_supply_uv_i), .regulator_out_uv_i(regulator_out_uv_i),
  .high_side_en_o(high_side_en_o), .low_side_en_o(low_side_en_o), .pwm_gate_o(pwm_gate_o),
  .square_wave_mode_o(square_wave_mode_o), .speed_pulse_out_o(speed_pulse_out_o),
  .lock_flag_out_o(lock_flag_out_o));

// ---- dv/fmpc_motor_model.sv ----
// Behavioural fan motor whose Hall sensor toggles while the low sides drive it
`timescale 1ns/1ps
module fmpc_motor_model (
  input wire logic clk_i,
  input wire logic low_side_en_i,
  input wire logic stall_i,
  input wire logic [7:0] half_period_i,
  output logic hall_o
);
  logic [7:0] cnt_q;
  initial begin
    hall_o = 1'b0;
    cnt_q = 8'h00;
  end
  // A stalled or undriven rotor gives no Hall edges
  always @(negedge clk_i) begin
    if (stall_i || !low_side_en_i) begin
      cnt_q <= 8'h00;
    end else if (cnt_q >= half_period_i) begin
      cnt_q <= 8'h00;
      hall_o <= !hall_o;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule : fmpc_motor_model

// ---- dv/test_fan_motor_protection_control.sv ----
// Self-checking bench for the fan motor protection control block
`timescale 1ns/1ps
module test_fan_motor_protection_control;
  import fmpc_pkg::*;
  localparam int HS = 0, LS = 1, PW = 2, SQ = 3, SB = 4, LK = 6;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic analog_variant_i = 1'b0;
  logic pwm_duty_in_i = 1'b1;
  logic analog_speed_low_i = 1'b0;
  logic min_duty_select_i = 1'b0;
  logic pwm_on_i = 1'b0;
  logic current_sense_in_i = 1'b0;
  logic overtemp_shutdown_i = 1'b0;
  logic motor_supply_uv_i = 1'b0;
  logic regulator_out_uv_i = 1'b0;
  logic stall = 1'b0;
  logic thr_set = 1'b0;
  logic below_thr = 1'b0;
  logic rnd_pwm = 1'b1;
  logic [7:0] half_per = 8'h50;
  logic [3:0] notes_q[$];
  logic [3:0] cur;
  int seed = 55;
  int num_errors = 0;
  int n_tests = 0;
  string names[7] = '{"high_side_en", "low_side_en", "pwm_gate", "square_mode", "standby", "speed", "lock_flag"};
  wire hall_i;
  wire [6:0] obs;
  ////////////////////////////////////////
  fmpc_top #(.TICK_CYCLES(4)) dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .hall_i(hall_i),
    .lock_timing_select_i(FMPC_BAND_PD18K), .analog_variant_i(analog_variant_i), .pwm_duty_in_i(pwm_duty_in_i),
    .analog_speed_low_i(analog_speed_low_i), .min_duty_select_i(min_duty_select_i),
    .startup_thresh_set_i(thr_set), .below_startup_thresh_i(below_thr), .pwm_on_i(pwm_on_i),
    .current_sense_in_i(current_sense_in_i), .overtemp_shutdown_i(overtemp_shutdown_i),
    .motor_supply_uv_i(motor_supply_uv_i), .regulator_out_uv_i(regulator_out_uv_i),
    .high_side_en_o(obs[0]), .low_side_en_o(obs[1]), .pwm_gate_o(obs[2]), .square_wave_mode_o(obs[3]),
    .standby_allowed_o(obs[4]), .speed_pulse_out_o(obs[5]), .lock_flag_out_o(obs[6]));
  fmpc_motor_model motor_u (.clk_i(clk_i), .low_side_en_i(obs[1]), .stall_i(stall),
    .half_period_i(half_per), .hall_o(hall_i));
  initial begin
    forever #4 clk_i = !clk_i;
  end
  always @(negedge clk_i) begin
    if (rnd_pwm) pwm_on_i <= 1'($random(seed));
  end
  ////////////////////////////////////////
  event chk_ev;
  task automatic note(input int idx, input logic exp);
    notes_q.push_back({exp, 3'(idx)});
    -> chk_ev;
  endtask : note
  always @(chk_ev) begin
    while (notes_q.size() > 0) begin
      cur = notes_q.pop_front();
      n_tests++;
      if (obs[cur[2:0]] !== cur[3]) begin
        num_errors++;
        $display("[FAIL] %s expected %b seen %b", names[cur[2:0]], cur[3], obs[cur[2:0]]);
      end
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc
  task automatic wait_for(input int idx, input logic val, input int lim);
    int k;
    k = 0;
    while (obs[idx] !== val && k < lim) begin
      @(negedge clk_i);
      k++;
    end
    if (k >= lim) begin
      num_errors++;
      $display("[FAIL] wait %s expected %b seen %b", names[idx], val, obs[idx]);
      tally_and_finish();
    end
  endtask : wait_for
  task automatic spin();
    half_per = 8'h3c + 8'($random(seed) & 63);
    stall = 1'b0;
  endtask : spin
  ////////////////////////////////////////
  initial begin
    cyc(4);
    reset_n_i = 1'b1;
    spin();
    cyc(3000);
    note(LK, 1'b0);
    note(HS, 1'b1);
    note(SQ, 1'b0);
    note(SB, 1'b1);
    $display("spin test done");
    stall = 1'b1;
    wait_for(LK, 1'b1, 1400);
    note(HS, 1'b0);
    note(LS, 1'b1);
    note(SQ, 1'b1);
    wait_for(LS, 1'b0, 1300);
    note(HS, 1'b0);
    wait_for(HS, 1'b1, 18000);
    note(LK, 1'b1);
    spin();
    wait_for(LK, 1'b0, 400);
    $display("lock test done");
    for (int v = 0; v < 3; v++) begin
      analog_variant_i = (v == 1);
      thr_set = (v == 2);
      stall = 1'b1;
      wait_for(LK, 1'b1, 1400);
      wait_for(LS, 1'b0, 1300);
      pwm_duty_in_i = (v != 0);
      analog_speed_low_i = (v == 1);
      below_thr = (v == 2);
      cyc(v == 1 ? 60 : 500);
      note(LK, 1'b0);
      pwm_duty_in_i = 1'b1;
      analog_speed_low_i = 1'b0;
      below_thr = 1'b0;
      spin();
      wait_for(HS, 1'b1, 20);
    end
    analog_variant_i = 1'b0;
    thr_set = 1'b0;
    $display("quick start test done");
    min_duty_select_i = 1'b1;
    cyc(5);
    note(SB, 1'b0);
    stall = 1'b1;
    wait_for(LK, 1'b1, 1400);
    wait_for(LS, 1'b0, 1300);
    pwm_duty_in_i = 1'b0;
    cyc(500);
    note(LK, 1'b1);
    pwm_duty_in_i = 1'b1;
    wait_for(HS, 1'b1, 18000);
    spin();
    wait_for(LK, 1'b0, 400);
    min_duty_select_i = 1'b0;
    $display("minimum duty test done");
    rnd_pwm = 1'b0;
    cyc(1);
    pwm_on_i = 1'b0;
    current_sense_in_i = 1'b1;
    cyc(60);
    current_sense_in_i = 1'b0;
    cyc(5);
    note(HS, 1'b1);
    current_sense_in_i = 1'b1;
    cyc(140);
    note(HS, 1'b0);
    current_sense_in_i = 1'b0;
    cyc(10);
    note(HS, 1'b0);
    pwm_on_i = 1'b1;
    cyc(5);
    note(HS, 1'b1);
    rnd_pwm = 1'b1;
    $display("current limit test done");
    overtemp_shutdown_i = 1'b1;
    cyc(5);
    note(PW, 1'b0);
    cyc(450);
    note(LS, 1'b0);
    note(HS, 1'b0);
    overtemp_shutdown_i = 1'b0;
    cyc(5);
    note(PW, 1'b1);
    note(LS, 1'b1);
    $display("overtemperature test done");
    for (int i = 0; i < 2; i++) begin
      motor_supply_uv_i = (i == 0);
      regulator_out_uv_i = (i == 1);
      cyc(6);
      note(HS, 1'b0);
      note(LS, 1'b0);
      motor_supply_uv_i = 1'b0;
      regulator_out_uv_i = 1'b0;
      cyc(6);
      note(LS, 1'b1);
    end
    $display("undervoltage test done");
    reset_n_i = 1'b0;
    cyc(4);
    note(LK, 1'b0);
    note(HS, 1'b0);
    reset_n_i = 1'b1;
    cyc(20);
    $display("reset test done");
    tally_and_finish();
  end
endmodule : test_fan_motor_protection_control
